// ### hw/nv_access_consts.vh
// Offsets, field positions, reset values and timing for the data EEPROM sequencer
`ifndef NV_ACCESS_CONSTS_VH
`define NV_ACCESS_CONSTS_VH

// ****************************************************************
// Register byte offsets on the Wishbone bus
// ****************************************************************
`define OFF_BANK_SELECT     8'h00
`define OFF_INDIRECT_PTR    8'h04
`define OFF_INDIRECT_PORT   8'h08
`define OFF_NV_ADDRESS      8'h0c
`define OFF_NV_DATA         8'h10
`define OFF_IRQ_STATUS      8'h14
`define OFF_IRQ_CLEAR       8'h18
`define OFF_IRQ_ENABLE      8'h1c
`define OFF_SEQ_STATE       8'h20

// ****************************************************************
// Indirect window onto the control register
// ****************************************************************
`define BANK_CTL            8'h01
`define PTR_CTL             8'h40

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTL_READ_START      0
`define CTL_READ_ENABLE     1
`define CTL_WRITE_START     2
`define CTL_WRITE_ENABLE    3

// ****************************************************************
// Interrupt status fields
// ****************************************************************
`define IRQ_WRITE_DONE      0
`define IRQ_ACCESS_FAIL     1
`define IRQ_BITS            2

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_BYTE            8'h00
`define RST_IRQ             2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS       4
`define WRITE_TIME_NS       2000
`define READ_TIME_NS        8
`define WRITE_CYCLES        ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLES         ((`READ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### hw/nv_array.v
// Byte-wide storage array with registered read data
`timescale 1ns/1ps

module nv_array #(
    parameter ADDR_W = 5,
    parameter DATA_W = 8
)(
    // Clock and reset
    input  wire              clk,
    input  wire              arst_n,
    // Access port
    input  wire [ADDR_W-1:0] addr,
    input  wire [DATA_W-1:0] wdata,
    input  wire              we,
    input  wire              re,
    output reg  [DATA_W-1:0] rdata
);

    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Array write, no reset so it maps onto plain storage
    always @(posedge clk)
    begin
        if (we)
            mem[addr] <= wdata;
    end

    // Read data held in a register until the next read
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= {DATA_W{1'b0}};
        else if (re)
            rdata <= mem[addr];
    end

endmodule

// ### hw/nv_access_seq.v
// Data EEPROM access sequencer with Wishbone register slave and interrupt
`timescale 1ns/1ps
`include "nv_access_consts.vh"

module nv_access_seq #(
    parameter ADDR_W       = 5,
    parameter DATA_W       = 8,
    parameter WRITE_CYCLES = `WRITE_CYCLES,
    parameter READ_CYCLES  = `READ_CYCLES
)(
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Processor power state, same clock domain
    input  wire        cpu_halt,
    // Interrupt request, level
    output wire        irq
);

    // ****************************************************************
    // Local definitions
    // ****************************************************************
    localparam ST_IDLE  = 2'd0;
    localparam ST_READ  = 2'd1;
    localparam ST_LATCH = 2'd2;
    localparam ST_WRITE = 2'd3;
    localparam CNT_W    = 16;

    // Register hit decode, shared by read and write paths
    function hit;
        input [7:0] adr;
        input [7:0] off;
        begin
            hit = (adr == off);
        end
    endfunction

    // ****************************************************************
    // Storage
    // ****************************************************************
    reg  [7:0]        bank_select;
    reg  [7:0]        indirect_pointer;
    reg  [ADDR_W-1:0] nv_address_reg;
    reg  [DATA_W-1:0] nv_data_reg;
    reg               write_enable_bit;
    reg               read_enable_bit;
    reg               write_busy;
    reg               read_busy;
    reg  [1:0]        state;
    reg  [CNT_W-1:0]  cnt;
    reg  [ADDR_W-1:0] lat_addr;
    reg  [DATA_W-1:0] lat_data;
    reg  [`IRQ_BITS-1:0] irq_status;
    reg  [`IRQ_BITS-1:0] irq_enable;

    wire [DATA_W-1:0] mem_q;
    reg               mem_we;
    reg               mem_re;

    // ****************************************************************
    // Bus access decode
    // ****************************************************************
    wire        access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr_acc   = access & wb_we_i & wb_sel_i[0];
    wire [7:0]  wbyte    = wb_dat_i[7:0];
    wire        idle     = (state == ST_IDLE);
    // Indirect window only opens at pointer 40h in bank 1
    wire        ctl_open = (bank_select == `BANK_CTL) &&
                           (indirect_pointer == `PTR_CTL);
    wire        ctl_wr   = wr_acc & hit(wb_adr_i, `OFF_INDIRECT_PORT) & ctl_open;

    // Start requests qualified by enables already stored, both together refused
    wire        both_start = wbyte[`CTL_READ_START] & wbyte[`CTL_WRITE_START];
    wire        start_rd   = ctl_wr & idle & ~both_start & wbyte[`CTL_READ_START] &
                             read_enable_bit;
    wire        start_wr   = ctl_wr & idle & ~both_start & wbyte[`CTL_WRITE_START] &
                             write_enable_bit;

    wire [7:0]  ctl_value  = {4'h0, write_enable_bit, write_busy,
                              read_enable_bit, read_busy};

    // Sequencer events
    wire        wr_end   = (state == ST_WRITE) & (cnt == 1) & ~cpu_halt;
    wire        rd_end   = (state == ST_LATCH) & ~cpu_halt;
    wire        fail_evt = ~idle & cpu_halt;

    // ****************************************************************
    // Wishbone answer
    // ****************************************************************

    // Ack one cycle after the request, dropped the following cycle
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= access;
    end

    // Read data registered together with ack, unmapped reads return zero
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_dat_o <= 32'h0000_0000;
        else if (access)
        begin
            wb_dat_o <= 32'h0000_0000;
            if (hit(wb_adr_i, `OFF_BANK_SELECT))
                wb_dat_o[7:0] <= bank_select;
            if (hit(wb_adr_i, `OFF_INDIRECT_PTR))
                wb_dat_o[7:0] <= indirect_pointer;
            if (hit(wb_adr_i, `OFF_INDIRECT_PORT) && ctl_open)
                wb_dat_o[7:0] <= ctl_value;
            if (hit(wb_adr_i, `OFF_NV_ADDRESS))
                wb_dat_o[ADDR_W-1:0] <= nv_address_reg;
            if (hit(wb_adr_i, `OFF_NV_DATA))
                wb_dat_o[DATA_W-1:0] <= nv_data_reg;
            if (hit(wb_adr_i, `OFF_IRQ_STATUS))
                wb_dat_o[`IRQ_BITS-1:0] <= irq_status;
            if (hit(wb_adr_i, `OFF_IRQ_ENABLE))
                wb_dat_o[`IRQ_BITS-1:0] <= irq_enable;
            if (hit(wb_adr_i, `OFF_SEQ_STATE))
                wb_dat_o[1:0] <= state;
        end
    end

    // ****************************************************************
    // Bank and pointer
    // ****************************************************************

    // Reset to bank 0 keeps the control register out of reach
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bank_select      <= `RST_BYTE;
            indirect_pointer <= `RST_BYTE;
        end
        else
        begin
            if (wr_acc && hit(wb_adr_i, `OFF_BANK_SELECT))
                bank_select <= wbyte;
            if (wr_acc && hit(wb_adr_i, `OFF_INDIRECT_PTR))
                indirect_pointer <= wbyte;
        end
    end

    // ****************************************************************
    // Address and data registers
    // ****************************************************************

    // Software writes ignored while an access runs, so the access is stable
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nv_address_reg <= {ADDR_W{1'b0}};
            nv_data_reg    <= {DATA_W{1'b0}};
        end
        else
        begin
            if (wr_acc && idle && hit(wb_adr_i, `OFF_NV_ADDRESS))
                nv_address_reg <= wbyte[ADDR_W-1:0];
            if (wr_acc && idle && hit(wb_adr_i, `OFF_NV_DATA))
                nv_data_reg <= wbyte[DATA_W-1:0];
            else if (rd_end)
                nv_data_reg <= mem_q;
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************

    // Enables follow software; start bits are set only through a qualified
    // request and cleared only by the sequencer
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            write_enable_bit <= 1'b0;
            read_enable_bit  <= 1'b0;
            write_busy       <= 1'b0;
            read_busy        <= 1'b0;
        end
        else
        begin
            if (ctl_wr)
            begin
                write_enable_bit <= wbyte[`CTL_WRITE_ENABLE];
                read_enable_bit  <= wbyte[`CTL_READ_ENABLE];
            end
            if (start_wr)
                write_busy <= 1'b1;
            else if (wr_end || (fail_evt && write_busy))
                write_busy <= 1'b0;
            if (start_rd)
                read_busy <= 1'b1;
            else if (rd_end || (fail_evt && read_busy))
                read_busy <= 1'b0;
        end
    end

    // ****************************************************************
    // Access sequencer
    // ****************************************************************

    // Address and data are captured at start, so later register writes
    // cannot reach the array mid-cycle
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state    <= ST_IDLE;
            cnt      <= {CNT_W{1'b0}};
            lat_addr <= {ADDR_W{1'b0}};
            lat_data <= {DATA_W{1'b0}};
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (start_wr)
                    begin
                        state    <= ST_WRITE;
                        cnt      <= WRITE_CYCLES[CNT_W-1:0];
                        lat_addr <= nv_address_reg;
                        lat_data <= nv_data_reg;
                    end
                    else if (start_rd)
                    begin
                        state    <= ST_READ;
                        cnt      <= READ_CYCLES[CNT_W-1:0];
                        lat_addr <= nv_address_reg;
                    end
                end
                ST_READ:
                begin
                    if (cpu_halt)
                        state <= ST_IDLE;
                    else if (cnt == 1)
                        state <= ST_LATCH;
                    else
                        cnt <= cnt - 1'b1;
                end
                ST_LATCH:
                begin
                    state <= ST_IDLE;
                end
                ST_WRITE:
                begin
                    if (cpu_halt)
                        state <= ST_IDLE;
                    else if (cnt == 1)
                        state <= ST_IDLE;
                    else
                        cnt <= cnt - 1'b1;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Array strobes: commit only at the end of an uninterrupted cycle
    always @*
    begin
        mem_we = wr_end;
        mem_re = (state == ST_READ) && (cnt == 1) && !cpu_halt;
    end

    nv_array #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_array (
        .clk    (clk),
        .arst_n (arst_n),
        .addr   (lat_addr),
        .wdata  (lat_data),
        .we     (mem_we),
        .re     (mem_re),
        .rdata  (mem_q)
    );

    // ****************************************************************
    // Interrupt status, clear and enable
    // ****************************************************************

    // Set wins over a clear in the same cycle so no event is lost
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_status <= `RST_IRQ;
            irq_enable <= `RST_IRQ;
        end
        else
        begin
            if (wr_acc && hit(wb_adr_i, `OFF_IRQ_ENABLE))
                irq_enable <= wbyte[`IRQ_BITS-1:0];
            irq_status[`IRQ_WRITE_DONE] <= wr_end |
                (irq_status[`IRQ_WRITE_DONE] &
                 ~(wr_acc & hit(wb_adr_i, `OFF_IRQ_CLEAR) &
                   wbyte[`IRQ_WRITE_DONE]));
            irq_status[`IRQ_ACCESS_FAIL] <= fail_evt |
                (irq_status[`IRQ_ACCESS_FAIL] &
                 ~(wr_acc & hit(wb_adr_i, `OFF_IRQ_CLEAR) &
                   wbyte[`IRQ_ACCESS_FAIL]));
        end
    end

    // Level output; the global mask lives in the processor core
    assign irq = |(irq_status & irq_enable);

endmodule

// ### testbench/nv_access_seq_chk.sv
// Port-level checker for the data EEPROM access sequencer
`timescale 1ns/1ps
`include "nv_access_consts.vh"

module nv_access_seq_chk (
    // Clock and reset
    input wire        clk,
    input wire        arst_n,
    // Wishbone slave pins
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Side pins
    input wire        cpu_halt,
    input wire        irq
);
    // ****************************************************************
    // Window shadow and properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    reg  [7:0] bank;
    reg  [7:0] ptr;
    wire       req    = wb_cyc_i && wb_stb_i;
    wire       rd_ack = req && wb_ack_o && !wb_we_i;
    wire       wr_ack = req && wb_ack_o && wb_we_i && wb_sel_i[0];
    // Shadow lags the design by one edge, harmless since reads follow later
    always @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            bank <= 8'h00;
            ptr  <= 8'h00;
        end
        else if (wr_ack && wb_adr_i == `OFF_BANK_SELECT)
            bank <= wb_dat_i[7:0];
        else if (wr_ack && wb_adr_i == `OFF_INDIRECT_PTR)
            ptr <= wb_dat_i[7:0];
    property p_ack_next;
        req && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(req);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_upper_zero;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_addr_bits;
        rd_ack && wb_adr_i == `OFF_NV_ADDRESS |-> wb_dat_o[7:5] == 3'h0;
    endproperty
    a_addr_bits: assert property (p_addr_bits) else $error("address top bits set");
    property p_ctl_bits;
        rd_ack && wb_adr_i == `OFF_INDIRECT_PORT |-> wb_dat_o[7:4] == 4'h0;
    endproperty
    a_ctl_bits: assert property (p_ctl_bits) else $error("control top bits set");
    property p_window;
        rd_ack && wb_adr_i == `OFF_INDIRECT_PORT && (bank != `BANK_CTL || ptr != `PTR_CTL)
            |-> wb_dat_o == 32'h0;
    endproperty
    a_window: assert property (p_window) else $error("control seen outside window");
    property p_irq_fall;
        $fell(irq) |-> $past(req && wb_we_i &&
            (wb_adr_i == `OFF_IRQ_CLEAR || wb_adr_i == `OFF_IRQ_ENABLE));
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
    property p_unmapped;
        rd_ack && wb_adr_i > `OFF_SEQ_STATE |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_irq: cover property ($rose(irq));
    c_halt: cover property (cpu_halt && !req);
    c_win: cover property (rd_ack && bank == `BANK_CTL && ptr == `PTR_CTL);
endmodule

bind nv_access_seq nv_access_seq_chk chk_u (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_halt(cpu_halt),
    .irq(irq));

// ### testbench/nv_access_seq_tb.sv
// Self-checking bench for the data EEPROM access sequencer
`timescale 1ns/1ps
`include "nv_access_consts.vh"

module nv_access_seq_tb;
    // ****************************************************************
    // Signals, clock and the design
    // ****************************************************************
    localparam P = `OFF_INDIRECT_PORT;
    reg          clk       = 1'b0;
    reg          arst_n    = 1'b0;
    reg          wb_cyc_i  = 1'b0;
    reg          wb_stb_i  = 1'b0;
    reg          wb_we_i   = 1'b0;
    reg  [7:0]   wb_adr_i  = 8'h00;
    reg  [3:0]   wb_sel_i  = 4'h0;
    reg  [3:0]   sel_n     = 4'hf;
    reg  [31:0]  wb_dat_i  = 32'h0;
    reg          cpu_halt  = 1'b0;
    wire [31:0]  wb_dat_o;
    wire         wb_ack_o;
    wire         irq;
    integer      err_count = 0;
    integer      checked   = 0;
    integer      seed      = 32'hbe4d961a;
    integer      cycles    = 0;
    integer      k;
    logic [7:0]  exp_q[$];
    logic [7:0]  msk_q[$];
    logic [7:0]  mem[0:31];
    logic [7:0]  adrs[0:3];
    logic [31:0] r;
    logic [7:0]  a;
    logic [7:0]  d;
    logic [7:0]  exp_v;
    logic [7:0]  msk_v;
    // Refusal table: written control byte and what must read back
    logic [47:0] tdin = 48'h00_01_05_0c_0f_00;
    logic [47:0] texp = 48'h00_00_00_08_0a_00;
    initial
        forever #2 clk = ~clk;
    // Short write time keeps the run brief; busy writes still fit inside it
    nv_access_seq #(.WRITE_CYCLES(40)) dut_u (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_halt(cpu_halt),
        .irq(irq));
    // ****************************************************************
    // Tasks and result side
    // ****************************************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Classic cycle held until ack; random upper bytes must be ignored
    task bus(input logic w, input logic [7:0] ad, dt, e, m);
        if (!w)
        begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= ad;
        wb_sel_i <= sel_n;
        wb_dat_i <= $random(seed) & 32'hffffff00 | dt;
        @(posedge clk);
        while (wb_ack_o !== 1'b1)
            @(posedge clk);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] ad, dt);
        bus(1'b1, ad, dt, 8'h00, 8'h00);
    endtask
    task rd(input logic [7:0] ad, e);
        bus(1'b0, ad, 8'h00, e, 8'hff);
    endtask
    task poll(input logic [7:0] bm);
        integer n;
        n = 0;
        bus(1'b0, P, 8'h00, 8'h00, 8'h00);
        while ((r[7:0] & bm) !== 8'h00 && n < 40)
        begin
            n = n + 1;
            bus(1'b0, P, 8'h00, 8'h00, 8'h00);
        end
        check({31'h0, n < 40}, 32'h1);
    endtask
    task nv_read(input logic [7:0] ad, e);
        wr(`OFF_NV_ADDRESS, ad);
        wr(P, 8'h02);
        wr(P, 8'h03);
        poll(8'h01);
        rd(`OFF_NV_DATA, e);
    endtask
    // Oldest note taken off the queue at each read answer
    always @(posedge clk)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
        begin
            exp_v = exp_q.pop_front();
            msk_v = msk_q.pop_front();
            if (msk_v != 8'h00)
                check(wb_dat_o & {24'hffffff, msk_v}, {24'h0, exp_v & msk_v});
        end
    // Hang guard
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            err_count = err_count + 1;
            end_sim;
        end
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (k = 0; k <= 40; k = k + 4)
            if (k != `OFF_IRQ_CLEAR)
                rd(k[7:0], 8'h00);
        // Bank zero blocks the port, wrong pointer too
        wr(`OFF_INDIRECT_PTR, `PTR_CTL);
        wr(P, 8'h0a);
        // Byte lane 0 not selected: the write must be dropped
        sel_n = 4'he;
        wr(`OFF_BANK_SELECT, `BANK_CTL);
        sel_n = 4'hf;
        rd(`OFF_BANK_SELECT, 8'h00);
        wr(`OFF_BANK_SELECT, `BANK_CTL);
        rd(P, 8'h00);
        wr(P, 8'h02);
        wr(`OFF_INDIRECT_PTR, 8'h41);
        rd(P, 8'h00);
        wr(`OFF_INDIRECT_PTR, `PTR_CTL);
        rd(P, 8'h02);
        for (k = 0; k < 6; k = k + 1)
        begin
            wr(P, tdin[47-8*k -: 8]);
            rd(P, texp[47-8*k -: 8]);
        end
        // Timed writes, busy-time disturbance, then reads back
        for (k = 0; k < 4; k = k + 1)
        begin
            a = $random(seed);
            d = $random(seed);
            adrs[k] = a & 8'h1f;
            mem[a[4:0]] = d;
            wr(`OFF_NV_ADDRESS, a);
            rd(`OFF_NV_ADDRESS, a & 8'h1f);
            wr(`OFF_NV_DATA, d);
            wr(P, 8'h08);
            wr(P, 8'h0c);
            rd(P, 8'h0c);
            rd(`OFF_SEQ_STATE, 8'h03);
            wr(`OFF_NV_ADDRESS, ~a);
            wr(`OFF_NV_DATA, ~d);
            poll(8'h04);
            rd(`OFF_NV_DATA, d);
            rd(`OFF_IRQ_STATUS, 8'h01);
            wr(P, 8'h00);
            wr(`OFF_NV_DATA, ~d);
            nv_read(a & 8'h1f, d);
            wr(P, 8'h00);
        end
        for (k = 0; k < 4; k = k + 1)
            nv_read(adrs[k], mem[adrs[k][4:0]]);
        // Interrupt raised, masked and cleared
        check({31'h0, irq}, 32'h0);
        wr(`OFF_IRQ_ENABLE, 8'h03);
        check({31'h0, irq}, 32'h1);
        wr(`OFF_IRQ_CLEAR, 8'h02);
        check({31'h0, irq}, 32'h1);
        wr(`OFF_IRQ_ENABLE, 8'h02);
        check({31'h0, irq}, 32'h0);
        wr(`OFF_IRQ_CLEAR, 8'h01);
        rd(`OFF_IRQ_STATUS, 8'h00);
        // Halt during a write makes it fail and leaves the byte alone
        wr(`OFF_NV_ADDRESS, adrs[0]);
        wr(`OFF_NV_DATA, ~mem[adrs[0][4:0]]);
        wr(P, 8'h08);
        wr(P, 8'h0c);
        cpu_halt <= 1'b1;
        @(posedge clk);
        cpu_halt <= 1'b0;
        rd(P, 8'h08);
        rd(`OFF_IRQ_STATUS, 8'h02);
        check({31'h0, irq}, 32'h1);
        nv_read(adrs[0], mem[adrs[0][4:0]]);
        wr(`OFF_IRQ_CLEAR, 8'h03);
        wr(P, 8'h00);
        wr(`OFF_BANK_SELECT, 8'h00);
        rd(P, 8'h00);
        end_sim;
    end
endmodule
